// File: src/chg_flags_pkg.sv
// register map, field positions and reset values of the event-flag bank
package chg_flags_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_FLAGS3  = 8'h0f;
    localparam logic [7:0] OFS_MASK3   = 8'h10;
    localparam logic [7:0] OFS_ADC_CTL = 8'h11;
    localparam logic [7:0] OFS_VBUS_HI = 8'h12;
    localparam logic [7:0] OFS_VBUS_LO = 8'h13;

    // reset values
    localparam logic [7:0] RST_FLAGS3  = 8'h00;
    localparam logic [7:0] RST_MASK3   = 8'h00;
    localparam logic [7:0] RST_ADC_CTL = 8'h00;
    localparam logic [7:0] RST_RESULT  = 8'h00;

    // flag bit positions
    localparam int unsigned BIT_BUS_INSERT = 7;
    localparam int unsigned BIT_CELL_ARR   = 6;
    localparam int unsigned BIT_WD_EXP     = 5;
    localparam int unsigned BIT_ADAPT_GONE = 4;
    localparam int unsigned BIT_BUS_ABSENT = 3;
    localparam int unsigned BIT_UCP_EXP    = 2;
    localparam int unsigned BIT_CONV_DONE  = 1;
    localparam int unsigned BIT_PIN_FAIL   = 0;

    // conversion control fields
    localparam int unsigned BIT_CONV_EN     = 7;
    localparam int unsigned BIT_ONE_SHOT    = 6;
    localparam int unsigned CHAN_OFF_HI     = 5;
    localparam int unsigned CHAN_OFF_LO     = 1;
    localparam int unsigned NUM_CHAN        = 5;
    localparam logic [7:0]  ADC_CTL_WR_MASK = 8'hfe;

    // bus-voltage result layout, 4 mV per lsb
    localparam int unsigned RESULT_W     = 12;
    localparam int unsigned RESULT_HI_W  = 4;

endpackage

// File: src/level_sync.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module level_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_out = sync_q;
    assign rise     = sync_q & ~prev_q & {WIDTH{clk_en}};
    assign fall     = ~sync_q & prev_q & {WIDTH{clk_en}};
endmodule

// File: src/charger_event_flags_adc_ctrl.sv
// third event-flag group, its mask, conversion control and bus-voltage result
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Notes on behaviour
// - bus rising above present threshold sets bit7
// - cell above 2.8V sets bit6 when qualified
// - watchdog expiry sets bit5; register reset clears
// - adapter below threshold minus hysteresis sets bit4
// - bus below threshold minus hysteresis sets bit3
// - input under-current timeout sets bit2
// - one-shot pass complete sets bit1
// - pin short while charging sets bit0
// - reading the flag register clears flags
// - unmasked set flag asserts interrupt
// - masked flag still sets; masks reset zero
// - enable bit, self-clears after one-shot, watchdog
// - bit6 selects continuous or one-shot mode
// - bits5..1 disable channels; bit0 reserved
// - result high nibble in bits3:0, upper zero
// - result low byte at offset 0x13
// ----------------------------------------------------------------------------
module charger_event_flags_adc_ctrl (
    input  wire logic                         clock,
    input  wire logic                         rstn,
    input  wire logic                         clk_en,
    input  wire logic                         reg_reset,
    input  wire logic                         rd_en,
    input  wire logic                         wr_en,
    input  wire logic [chg_flags_pkg::ADDR_W-1:0] addr,
    input  wire logic [chg_flags_pkg::DATA_W-1:0] wr_data,
    output logic      [chg_flags_pkg::DATA_W-1:0] rd_data,
    input  wire logic                         bus_present,
    input  wire logic                         adapter_present,
    input  wire logic                         cell_above_2v8,
    input  wire logic                         watchdog_expired,
    input  wire logic                         input_undercurrent_timeout,
    input  wire logic                         charge_enabled,
    input  wire logic                         pin_short_detect,
    input  wire logic                         conv_pass_done,
    input  wire logic                         result_valid,
    input  wire logic [chg_flags_pkg::RESULT_W-1:0] input_volt_result,
    output logic                              conv_enable,
    output logic                              conv_one_shot,
    output logic [chg_flags_pkg::NUM_CHAN-1:0] chan_off,
    output logic                              irq_out_n
);
    import chg_flags_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [5:0] pins_s;
    logic [5:0] pins_rise;
    logic [5:0] pins_fall;

    level_sync #(.WIDTH(6)) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .async_in ({pin_short_detect, input_undercurrent_timeout, watchdog_expired,
                    cell_above_2v8, adapter_present, bus_present}),
        .sync_out (pins_s),
        .rise     (pins_rise),
        .fall     (pins_fall)
    );

    logic flags_rd;
    logic mask_wr;
    logic ctl_wr;
    logic [7:0] flags_q;
    logic [7:0] mask_q;
    logic [7:0] ctl_q;
    logic [7:0] event_set;
    logic [RESULT_W-1:0] result_q;
    logic cell_qualify;

    assign flags_rd = clk_en && rd_en && (addr == OFS_FLAGS3);
    assign mask_wr  = clk_en && wr_en && (addr == OFS_MASK3);
    assign ctl_wr   = clk_en && wr_en && (addr == OFS_ADC_CTL);

    // ------------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------------
    assign cell_qualify = ctl_q[BIT_CONV_EN] | pins_s[1] | pins_s[0];

    always_comb begin
        event_set                 = '0;
        event_set[BIT_BUS_INSERT] = pins_rise[0];
        event_set[BIT_CELL_ARR]   = pins_rise[2] & cell_qualify;
        event_set[BIT_WD_EXP]     = pins_rise[3];
        event_set[BIT_ADAPT_GONE] = pins_fall[1];
        event_set[BIT_BUS_ABSENT] = pins_fall[0];
        event_set[BIT_UCP_EXP]    = pins_rise[4];
        event_set[BIT_CONV_DONE]  = clk_en & conv_pass_done
                                  & ctl_q[BIT_ONE_SHOT] & ctl_q[BIT_CONV_EN];
        event_set[BIT_PIN_FAIL]   = pins_rise[5] & charge_enabled;
    end

    // ------------------------------------------------------------------------
    // flag register: set wins over read clear
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_q <= RST_FLAGS3;
        end else if (clk_en) begin
            if (reg_reset) begin
                flags_q <= RST_FLAGS3;
            end else if (flags_rd) begin
                flags_q <= event_set;
            end else begin
                flags_q <= flags_q | event_set;
            end
        end
    end

    // ------------------------------------------------------------------------
    // mask register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_q <= RST_MASK3;
        end else if (clk_en) begin
            if (reg_reset) begin
                mask_q <= RST_MASK3;
            end else if (mask_wr) begin
                mask_q <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------------------
    // conversion control
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= RST_ADC_CTL;
        end else if (clk_en) begin
            if (reg_reset) begin
                ctl_q <= RST_ADC_CTL;
            end else begin
                if (ctl_wr) begin
                    ctl_q <= wr_data & ADC_CTL_WR_MASK;
                end
                if (pins_rise[3] ||
                    (conv_pass_done && ctl_q[BIT_ONE_SHOT] && ctl_q[BIT_CONV_EN])) begin
                    ctl_q[BIT_CONV_EN] <= 1'b0;
                end
            end
        end
    end

    assign conv_enable   = ctl_q[BIT_CONV_EN];
    assign conv_one_shot = ctl_q[BIT_ONE_SHOT];
    assign chan_off      = ctl_q[CHAN_OFF_HI:CHAN_OFF_LO];

    // ------------------------------------------------------------------------
    // bus-voltage result capture
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_q <= '0;
        end else if (clk_en) begin
            if (reg_reset) begin
                result_q <= '0;
            end else if (result_valid && ctl_q[BIT_CONV_EN] && !ctl_q[CHAN_OFF_HI]) begin
                result_q <= input_volt_result;
            end
        end
    end

    // ------------------------------------------------------------------------
    // read data, registered
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data <= RST_RESULT;
        end else if (clk_en && rd_en) begin
            unique case (addr)
                OFS_FLAGS3:  rd_data <= flags_q;
                OFS_MASK3:   rd_data <= mask_q;
                OFS_ADC_CTL: rd_data <= ctl_q;
                OFS_VBUS_HI: rd_data <= {4'h0, result_q[RESULT_W-1:8]};
                OFS_VBUS_LO: rd_data <= result_q[7:0];
                default:     rd_data <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_out_n <= 1'b1;
        end else if (clk_en) begin
            irq_out_n <= ~|(flags_q & ~mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_bus_insert;
        @(posedge clock) disable iff (!rstn)
        (clk_en && pins_rise[0] && !reg_reset) |=> flags_q[BIT_BUS_INSERT];
    endproperty
    a_bus_insert: assert property (p_bus_insert) else $error("bus insert lost");

    property p_cell_gate;
        @(posedge clock) disable iff (!rstn)
        (clk_en && pins_rise[2] && !cell_qualify && !flags_q[BIT_CELL_ARR])
            |=> !flags_q[BIT_CELL_ARR];
    endproperty
    a_cell_gate: assert property (p_cell_gate) else $error("cell flag unqualified");

    property p_reg_reset;
        @(posedge clock) disable iff (!rstn)
        (clk_en && reg_reset) |=> (flags_q == 8'h00 && ctl_q == 8'h00);
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("reg reset missed");

    property p_absent;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !reg_reset && pins_fall[0]) |=> flags_q[BIT_BUS_ABSENT];
    endproperty
    a_absent: assert property (p_absent) else $error("bus absent lost");

    property p_read_clear;
        @(posedge clock) disable iff (!rstn)
        (flags_rd && !reg_reset) |=> (flags_q == $past(event_set))
            && (rd_data == $past(flags_q));
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read clear wrong");

    property p_irq;
        @(posedge clock) disable iff (!rstn)
        (clk_en && |(flags_q & ~mask_q)) |=> !irq_out_n;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not asserted");

    property p_irq_release;
        @(posedge clock) disable iff (!rstn)
        (clk_en && (flags_q & ~mask_q) == 8'h00) |=> irq_out_n;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq stuck");

    property p_oneshot_clear;
        @(posedge clock) disable iff (!rstn)
        (clk_en && !reg_reset && conv_pass_done && ctl_q[BIT_ONE_SHOT] && ctl_q[BIT_CONV_EN])
            |=> (!ctl_q[BIT_CONV_EN] && flags_q[BIT_CONV_DONE]);
    endproperty
    a_oneshot_clear: assert property (p_oneshot_clear) else $error("one-shot end wrong");

    property p_reserved;
        @(posedge clock) disable iff (!rstn)
        (clk_en && rd_en && addr == OFS_VBUS_HI)
            |=> rd_data == {4'h0, $past(result_q[RESULT_W-1:8])};
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

endmodule

// File: dv/chg_host_model.sv
// host register access model driving the strobe bus of the flag bank
`timescale 1ns/100ps
module chg_host_model (
    input  wire logic       clock,
    output logic            rd_en,
    output logic            wr_en,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
    end
    // called just after a rising edge; request held until the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(posedge clock);
        #1 wr_en = 1'b0;
    endtask
    // read also acknowledges pending flags
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd_en = 1'b1;
        @(posedge clock);
        #1 rd_en = 1'b0;
        @(posedge clock);
        #1 d = rd_data;
    endtask
endmodule

// File: dv/charger_event_flags_adc_ctrl_tb.sv
// self-checking bench for the event-flag bank and conversion control
`timescale 1ns/100ps
module charger_event_flags_adc_ctrl_tb;
    import chg_flags_pkg::*;
    logic clock, rstn, reg_reset, rd_en, wr_en, bus_present, adapter_present;
    logic cell_above_2v8, watchdog_expired, input_undercurrent_timeout;
    logic charge_enabled, pin_short_detect, conv_pass_done, result_valid;
    logic conv_enable, conv_one_shot, irq_out_n;
    logic [7:0] addr, wr_data, rd_data, v;
    logic [RESULT_W-1:0] input_volt_result;
    logic [NUM_CHAN-1:0] chan_off;
    int err_total, cmp_count, cyc;

    charger_event_flags_adc_ctrl i_charger_event_flags_adc_ctrl (.clock(clock), .rstn(rstn),
        .clk_en(1'b1), .reg_reset(reg_reset), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .bus_present(bus_present),
        .adapter_present(adapter_present), .cell_above_2v8(cell_above_2v8),
        .watchdog_expired(watchdog_expired),
        .input_undercurrent_timeout(input_undercurrent_timeout),
        .charge_enabled(charge_enabled), .pin_short_detect(pin_short_detect),
        .conv_pass_done(conv_pass_done), .result_valid(result_valid),
        .input_volt_result(input_volt_result), .conv_enable(conv_enable),
        .conv_one_shot(conv_one_shot), .chan_off(chan_off), .irq_out_n(irq_out_n));
    chg_host_model i_chg_host_model (.clock(clock), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic fire(input int b);
        case (b)
            7: bus_present = 1'b1;
            6: cell_above_2v8 = 1'b1;
            5: watchdog_expired = 1'b1;
            4: adapter_present = 1'b0;
            3: bus_present = 1'b0;
            2: input_undercurrent_timeout = 1'b1;
            1: begin
                i_chg_host_model.wr(OFS_ADC_CTL, 8'hc0);
                tick(1);
                conv_pass_done = 1'b1;
                tick(1);
                conv_pass_done = 1'b0;
            end
            default: begin
                charge_enabled = 1'b1;
                pin_short_detect = 1'b1;
            end
        endcase
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end

    initial begin
        {rstn, reg_reset, bus_present, cell_above_2v8, watchdog_expired} = 5'b0;
        {input_undercurrent_timeout, charge_enabled, pin_short_detect} = 3'b0;
        {conv_pass_done, result_valid, input_volt_result} = '0;
        adapter_present = 1'b1;
        tick(2);
        rstn = 1'b1;
        tick(4);
        // reset values, unmapped address
        for (int a = OFS_FLAGS3; a <= OFS_VBUS_LO + 1; a++) begin
            i_chg_host_model.rd(8'(a), v);
            chk("reset value", 8'h00, v);
        end
        chk("irq idle", 8'h01, {7'h0, irq_out_n});
        i_chg_host_model.wr(OFS_FLAGS3, 8'hff);
        i_chg_host_model.rd(OFS_FLAGS3, v);
        chk("flags not writable", 8'h00, v);
        // each event unmasked: flag, interrupt, read clear, release
        for (int b = 7; b >= 0; b--) begin
            fire(b);
            tick(6);
            chk("irq asserted", 8'h00, {7'h0, irq_out_n});
            i_chg_host_model.rd(OFS_FLAGS3, v);
            chk("event flag", 8'h01 << b, v);
            tick(2);
            chk("irq released", 8'h01, {7'h0, irq_out_n});
            i_chg_host_model.rd(OFS_FLAGS3, v);
            chk("flag read clear", 8'h00, v);
            if (b == 1) begin
                i_chg_host_model.rd(OFS_ADC_CTL, v);
                chk("one-shot self clear", 8'h40, v);
            end
        end
        // one-shot completion landing on the read edge survives the clear
        i_chg_host_model.wr(OFS_ADC_CTL, 8'hc0);
        conv_pass_done = 1'b1;
        i_chg_host_model.rd(OFS_FLAGS3, v);
        conv_pass_done = 1'b0;
        chk("read during event", 8'h00, v);
        i_chg_host_model.rd(OFS_FLAGS3, v);
        chk("event kept over read", 8'h02, v);
        // control fields, masked watchdog event clears enable
        watchdog_expired = 1'b0;
        i_chg_host_model.wr(OFS_ADC_CTL, 8'hff);
        i_chg_host_model.wr(OFS_MASK3, 8'hff);
        i_chg_host_model.rd(OFS_MASK3, v);
        chk("mask rw", 8'hff, v);
        i_chg_host_model.rd(OFS_ADC_CTL, v);
        chk("ctl reserved bit", 8'hfe, v);
        chk("chan off", 8'h1f, {3'h0, chan_off});
        chk("mode enable", 8'h03, {6'h0, conv_enable, conv_one_shot});
        watchdog_expired = 1'b1;
        tick(6);
        chk("masked irq", 8'h01, {7'h0, irq_out_n});
        i_chg_host_model.rd(OFS_FLAGS3, v);
        chk("masked flag", 8'h20, v);
        i_chg_host_model.rd(OFS_ADC_CTL, v);
        chk("watchdog clears enable", 8'h7e, v);
        // bus-voltage result split, done pulse ignored in continuous mode
        i_chg_host_model.wr(OFS_ADC_CTL, 8'h80);
        input_volt_result = 12'habc;
        result_valid = 1'b1;
        conv_pass_done = 1'b1;
        tick(1);
        result_valid = 1'b0;
        conv_pass_done = 1'b0;
        tick(1);
        i_chg_host_model.rd(OFS_VBUS_HI, v);
        chk("result high", 8'h0a, v);
        i_chg_host_model.rd(OFS_VBUS_LO, v);
        chk("result low", 8'hbc, v);
        i_chg_host_model.rd(OFS_FLAGS3, v);
        chk("no done flag when continuous", 8'h00, v);
        i_chg_host_model.rd(OFS_ADC_CTL, v);
        chk("continuous keeps enable", 8'h80, v);
        // register reset
        reg_reset = 1'b1;
        tick(1);
        reg_reset = 1'b0;
        tick(1);
        i_chg_host_model.rd(OFS_MASK3, v);
        chk("mask after reg reset", 8'h00, v);
        i_chg_host_model.rd(OFS_ADC_CTL, v);
        chk("ctl after reg reset", 8'h00, v);
        results();
    end
endmodule
